/* File: mcspi_top.sv */
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
module mcspi_top import mcspi_pkg::*; #(
  parameter int WORD_BITS = DEF_WORD_BITS,
  parameter int DIV_W     = DEF_DIV_W
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // rate clock pin
  input  wire logic              rate_clk_i,
  // transmit bit clock pin
  input  wire logic              transmit_bit_clock_i,
  output logic                   transmit_bit_clock_o,
  output logic                   transmit_bit_clock_oe,
  // transmit frame sync pin (slave enable)
  input  wire logic              transmit_frame_sync_i,
  output logic                   transmit_frame_sync_o,
  output logic                   transmit_frame_sync_oe,
  // receive frame sync pin
  input  wire logic              receive_frame_sync_i,
  // serial data
  input  wire logic              serial_data_in,
  output logic                   serial_data_out,
  output logic                   serial_data_out_oe
);
  localparam int CW = $clog2(WORD_BITS + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(WORD_BITS);
  localparam logic [CW-1:0] CNT_LAST = CW'(WORD_BITS - 1);

  if (WORD_BITS < 2 || WORD_BITS > DATA_W) begin : g_bad_word
    $error("mcspi_top: word width out of range");
  end
  if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div
    $error("mcspi_top: divide width out of range");
  end

  typedef struct packed {
    mcspi_cfg_t           cfg;
    logic [DIV_W-1:0]     div;
    logic [WORD_BITS-1:0] tx_buf;
    logic                 tx_pend;
    logic [WORD_BITS-1:0] sh_tx;
    logic [WORD_BITS-1:0] sh_rx;
    logic [WORD_BITS-1:0] rx_data;
    logic                 rx_valid;
    logic [CW-1:0]        cnt;
    mcspi_state_t         state;
    logic                 sel;
    logic                 ck_en;
    logic                 oe;
    logic                 clk_o;
    logic                 fs_o;
    logic                 dout;
    logic [DATA_W-1:0]    rdata;
    logic                 prev_ext;
    logic                 prev_clk;
  } mcspi_st_t;

  mcspi_st_t   st_r;
  mcspi_st_t   st_nxt;
  mcspi_pins_t pins_raw;
  mcspi_pins_t pins_s;
  logic        gen_level;
  logic        gen_rise;
  logic        gen_fall;
  logic        nodly;
  logic        dly;
  logic        spi_on;
  logic        is_master;
  logic        ext_rise;
  logic        sel_in;
  logic        rx_on;
  logic        clk_in;
  logic        e_rise;
  logic        e_fall;
  logic        smp;
  logic        lch;
  logic        do_smp;
  logic        do_lch;
  logic        resync_go;
  logic        gen_run;

  // every pin input crosses two flops before any logic reads it
  always_comb begin
    pins_raw.rate_clk = rate_clk_i;
    pins_raw.rx_sync  = receive_frame_sync_i;
    pins_raw.tx_sync  = transmit_frame_sync_i;
    pins_raw.tx_clk   = transmit_bit_clock_i;
    pins_raw.din      = serial_data_in;
  end

  mcspi_sync #(
    .W        (PINS_W)
  ) u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  mcspi_rategen #(
    .DIV_W     (DIV_W)
  ) u_rategen (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .run       (gen_run),
    .src_cpu   (st_r.cfg.rate_source_select),
    .ext_tick  (ext_rise),
    .restart   (resync_go),
    .div       (st_r.div),
    .gen_level (gen_level),
    .gen_rise  (gen_rise),
    .gen_fall  (gen_fall)
  );

  // mode decode, edge selection and polarity handling
  always_comb begin
    nodly     = (st_r.cfg.clock_stop_select == STOP_NODLY);
    dly       = (st_r.cfg.clock_stop_select == STOP_DLY);
    spi_on    = st_r.cfg.enable & (nodly | dly);
    is_master = st_r.cfg.master;
    gen_run   = spi_on & is_master;
    ext_rise  = pins_s.rate_clk & ~st_r.prev_ext;
    sel_in    = pins_s.tx_sync ^ st_r.cfg.transmit_sync_polarity;
    rx_on     = pins_s.rx_sync ^ st_r.cfg.receive_sync_polarity;
    clk_in    = pins_s.tx_clk ^ st_r.cfg.transmit_clock_polarity;
    // an inactive slave sees no clock edges at all
    e_rise    = is_master ? gen_rise : (clk_in & ~st_r.prev_clk & sel_in);
    e_fall    = is_master ? gen_fall : (~clk_in & st_r.prev_clk & sel_in);
    smp       = nodly ? e_fall : e_rise;
    lch       = nodly ? e_rise : e_fall;
    do_smp    = smp && (st_r.cnt != CNT_FULL) && (is_master || rx_on) &&
                ((st_r.state == ST_SHIFT) || (st_r.state == ST_LEAD && gen_rise));
    do_lch    = lch && (st_r.state == ST_SHIFT) && (st_r.cnt != CNT_FULL);
    // receive sync taken only on a rate clock rising edge
    resync_go = st_r.cfg.frame_resync_enable & ext_rise & rx_on;
  end

  // register port, transfer sequencer and pin drive
  always_comb begin
    st_nxt          = st_r;
    st_nxt.prev_ext = pins_s.rate_clk;
    st_nxt.prev_clk = clk_in;
    st_nxt.rdata    = '0;

    // writes
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CTRL: st_nxt.cfg = mcspi_cfg_t'(reg_wdata[CFG_W-1:0]);
        ADDR_DIV:  st_nxt.div = reg_wdata[DIV_W-1:0];
        ADDR_TX: begin
          st_nxt.tx_buf  = reg_wdata[WORD_BITS-1:0];
          st_nxt.tx_pend = 1'b1;
        end
        default: ;
      endcase
    end

    // reads; unmapped offsets answer zero
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL: st_nxt.rdata = DATA_W'(st_r.cfg);
        ADDR_DIV:  st_nxt.rdata = DATA_W'(st_r.div);
        ADDR_TX:   st_nxt.rdata = DATA_W'(st_r.tx_buf);
        ADDR_RX: begin
          st_nxt.rdata    = DATA_W'(st_r.rx_data);
          st_nxt.rx_valid = 1'b0;
        end
        ADDR_STAT: begin
          st_nxt.rdata[STAT_BUSY] = (st_r.state != ST_IDLE) | st_r.tx_pend;
          st_nxt.rdata[STAT_RXV]  = st_r.rx_valid;
          st_nxt.rdata[STAT_SEL]  = sel_in;
        end
        default: ;
      endcase
    end

    // sequencer
    unique case (st_r.state)
      ST_IDLE: begin
        st_nxt.ck_en = 1'b0;
        if (spi_on && is_master && st_r.tx_pend) begin
          st_nxt.sh_tx   = st_r.tx_buf;
          // a word written in the start cycle stays pending for the next transfer
          st_nxt.tx_pend = reg_wr && (reg_addr == ADDR_TX);
          st_nxt.cnt     = '0;
          st_nxt.state   = ST_ARM;
        end else if (spi_on && !is_master && sel_in) begin
          st_nxt.sh_tx   = st_r.tx_buf;
          st_nxt.tx_pend = reg_wr && (reg_addr == ADDR_TX);
          st_nxt.cnt     = '0;
          st_nxt.oe      = 1'b1;
          st_nxt.state   = ST_SHIFT;
        end
      end
      ST_ARM: begin
        // enable goes active at a phase edge so the lead time is exact
        if (!spi_on) begin
          st_nxt.state = ST_IDLE;
        end else if (nodly && gen_fall) begin
          st_nxt.sel   = 1'b1;
          st_nxt.ck_en = 1'b1;
          st_nxt.state = ST_SHIFT;
        end else if (dly && gen_rise) begin
          st_nxt.sel   = 1'b1;
          st_nxt.state = ST_LEAD;
        end
      end
      ST_LEAD: begin
        // clock held at idle for one whole period in delay mode
        if (!spi_on) begin
          st_nxt.sel   = 1'b0;
          st_nxt.oe    = 1'b0;
          st_nxt.state = ST_IDLE;
        end else begin
          if (gen_fall) begin
            st_nxt.oe = 1'b1;
          end
          if (gen_rise) begin
            st_nxt.ck_en = 1'b1;
            st_nxt.state = ST_SHIFT;
          end
        end
      end
      ST_SHIFT: begin
        if (!spi_on) begin
          st_nxt.sel   = 1'b0;
          st_nxt.oe    = 1'b0;
          st_nxt.ck_en = 1'b0;
          st_nxt.state = ST_IDLE;
        end else if (!is_master) begin
          if (!sel_in) begin
            st_nxt.oe    = 1'b0;
            st_nxt.state = ST_IDLE;
          end
        end else if (nodly && do_smp && st_r.cnt == CNT_LAST) begin
          st_nxt.ck_en = 1'b0;
          st_nxt.state = ST_TRAIL;
        end else if (dly && gen_fall && st_r.cnt == CNT_FULL) begin
          st_nxt.oe    = 1'b0;
          st_nxt.ck_en = 1'b0;
          st_nxt.state = ST_TRAIL;
        end
      end
      ST_TRAIL: begin
        if (!spi_on) begin
          st_nxt.sel   = 1'b0;
          st_nxt.oe    = 1'b0;
          st_nxt.state = ST_IDLE;
        end else if (nodly) begin
          if (gen_rise) begin
            st_nxt.oe = 1'b0;
          end
          if (gen_fall) begin
            st_nxt.sel   = 1'b0;
            st_nxt.state = ST_IDLE;
          end
        end else if (gen_rise) begin
          st_nxt.sel   = 1'b0;
          st_nxt.state = ST_IDLE;
        end
      end
      default: st_nxt.state = ST_IDLE;
    endcase

    // shift path; a new word sets the flag after any read clear
    if (do_smp) begin
      st_nxt.sh_rx = {st_r.sh_rx[WORD_BITS-2:0], pins_s.din};
      st_nxt.cnt   = CW'(st_r.cnt + CW'(1));
      if (st_r.cnt == CNT_LAST) begin
        st_nxt.rx_data  = {st_r.sh_rx[WORD_BITS-2:0], pins_s.din};
        st_nxt.rx_valid = 1'b1;
      end
    end
    if (do_lch) begin
      if (is_master) begin
        st_nxt.oe = 1'b1;
      end
      // a launch edge before the first sample (no-delay mode) only opens the master driver; later ones advance
      if (st_r.cnt != '0) begin
        st_nxt.sh_tx = {st_r.sh_tx[WORD_BITS-2:0], 1'b0};
      end
    end

    // pins, registered so every output comes from a flop
    // next polarity, as the pin enables use it: no false enable when polarity is set
    st_nxt.clk_o = (gen_level & st_nxt.ck_en) ^ st_nxt.cfg.transmit_clock_polarity;
    st_nxt.fs_o  = st_nxt.sel ^ st_nxt.cfg.transmit_sync_polarity;
    st_nxt.dout  = st_nxt.sh_tx[WORD_BITS-1];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r       <= '0;
      st_r.cfg   <= mcspi_cfg_t'(CFG_RST);
      st_r.state <= ST_IDLE;
      st_r.fs_o  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // directions come straight from the control word
  logic clk_oe_r;
  logic fs_oe_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      clk_oe_r <= 1'b0;
      fs_oe_r  <= 1'b0;
    end else begin
      clk_oe_r <= st_nxt.cfg.transmit_clock_direction;
      fs_oe_r  <= st_nxt.cfg.transmit_sync_direction;
    end
  end

  assign reg_rdata              = st_r.rdata;
  assign transmit_bit_clock_o   = st_r.clk_o;
  assign transmit_bit_clock_oe  = clk_oe_r;
  assign transmit_frame_sync_o  = st_r.fs_o;
  assign transmit_frame_sync_oe = fs_oe_r;
  assign serial_data_out        = st_r.dout;
  assign serial_data_out_oe     = st_r.oe;

  sequence s_word_done;
    st_r.cnt == CNT_FULL;
  endsequence

  sequence s_wind_down;
    st_r.state inside {ST_IDLE, ST_TRAIL};
  endsequence

  property p_smp_nodly;
    @(posedge clk_sys) disable iff (sys_rst)
      is_master && nodly && !gen_fall |=> $stable(st_r.sh_rx);
  endproperty
  a_smp_nodly: assert property (p_smp_nodly) else $error("sampled off falling edge");

  property p_smp_dly;
    @(posedge clk_sys) disable iff (sys_rst)
      is_master && dly && !gen_rise |=> $stable(st_r.sh_rx);
  endproperty
  a_smp_dly: assert property (p_smp_dly) else $error("sampled off rising edge");

  property p_lead;
    @(posedge clk_sys) disable iff (sys_rst)
      $rose(st_r.sel) && dly |->
        (st_r.clk_o == st_r.cfg.transmit_clock_polarity && st_r.cnt == '0) [*2];
  endproperty
  a_lead: assert property (p_lead) else $error("clock moved during enable lead");

  property p_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(st_r.sel) && spi_on |-> s_word_done;
  endproperty
  a_hold: assert property (p_hold) else $error("enable dropped before word end");

  property p_release;
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(st_r.oe) && is_master && spi_on |-> s_word_done and s_wind_down;
  endproperty
  a_release: assert property (p_release) else $error("master output released early");

  property p_slave_hiz;
    @(posedge clk_sys) disable iff (sys_rst)
      !is_master && st_r.state == ST_SHIFT && !sel_in |=> !st_r.oe ##1 !st_r.oe || sel_in;
  endproperty
  a_slave_hiz: assert property (p_slave_hiz) else $error("slave kept driving");

  property p_slave_drive;
    @(posedge clk_sys) disable iff (sys_rst)
      !is_master && spi_on && st_r.state == ST_IDLE && sel_in |=> st_r.oe;
  endproperty
  a_slave_drive: assert property (p_slave_drive) else $error("slave first bit late");

  property p_fs_pin;
    @(posedge clk_sys) disable iff (sys_rst)
      is_master && st_r.state == ST_SHIFT |-> st_r.fs_o != st_r.cfg.transmit_sync_polarity;
  endproperty
  a_fs_pin: assert property (p_fs_pin) else $error("enable pin not active");

  property p_resync;
    @(posedge clk_sys) disable iff (sys_rst)
      resync_go |=> !gen_level && !gen_rise;
  endproperty
  a_resync: assert property (p_resync) else $error("resync did not restart rate");

  property p_ignore;
    @(posedge clk_sys) disable iff (sys_rst)
      !is_master && !sel_in |=> $stable(st_r.sh_rx) && $stable(st_r.cnt);
  endproperty
  a_ignore: assert property (p_ignore) else $error("inactive slave took a clock");
endmodule : mcspi_top

/* File: mcspi_pkg.sv */
package mcspi_pkg;
  // Functional notes
  // - rate source is cpu clock or pin
  // - bit period is divide plus one inputs; a zero divide gives two
  // - high phase length depends on divide parity
  // - low phase length depends on divide parity
  // - no-delay mode samples falling, launches rising
  // - delay mode samples rising, launches falling
  // - master asserts enable before first rise
  // - master holds enable after last fall
  // - master releases data after last fall in no-delay mode, at the last fall in delay mode
  // - slave floats data when enable returns high
  // - first bit driven soon after enable
  // - frame sync inverted into active-low enable
  // - enable low before transfer's first rise
  // - resync samples receive sync on rate clock
  // - polarity bits invert timing references

  // geometry defaults
  localparam int          DEF_WORD_BITS = 8;
  localparam int          DEF_DIV_W     = 8;
  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 32;

  // register byte offsets
  localparam logic [4:0]  ADDR_CTRL     = 5'h00;
  localparam logic [4:0]  ADDR_DIV      = 5'h04;
  localparam logic [4:0]  ADDR_TX       = 5'h08;
  localparam logic [4:0]  ADDR_RX       = 5'h0c;
  localparam logic [4:0]  ADDR_STAT     = 5'h10;

  // clock-stop codes that run a transfer; others keep the port idle
  localparam logic [1:0]  STOP_NODLY    = 2'h2;
  localparam logic [1:0]  STOP_DLY      = 2'h3;

  // control word: cpu rate source selected after reset
  localparam int          CFG_W         = 11;
  localparam logic [10:0] CFG_RST       = 11'h200;

  // status bit positions
  localparam int          STAT_BUSY     = 0;
  localparam int          STAT_RXV      = 1;
  localparam int          STAT_SEL      = 2;

  // control word layout, msb first
  typedef struct packed {
    logic       frame_resync_enable;
    logic       rate_source_select;
    logic       transmit_sync_direction;
    logic       transmit_clock_direction;
    logic       receive_sync_polarity;
    logic       transmit_sync_polarity;
    logic       transmit_clock_polarity;
    logic [1:0] clock_stop_select;
    logic       master;
    logic       enable;
  } mcspi_cfg_t;

  // pin inputs that cross into the system clock
  localparam int PINS_W = 5;
  typedef struct packed {
    logic rate_clk;
    logic rx_sync;
    logic tx_sync;
    logic tx_clk;
    logic din;
  } mcspi_pins_t;

  typedef enum logic [2:0] {ST_IDLE, ST_ARM, ST_LEAD, ST_SHIFT, ST_TRAIL} mcspi_state_t;
endpackage : mcspi_pkg

/* File: mcspi_sync.sv */
`timescale 1ns/1ps
module mcspi_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // asynchronous inputs and their synchronised copies
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } mcspi_sync_st_t;

  mcspi_sync_st_t st_r;
  mcspi_sync_st_t st_nxt;

  if (W < 1) begin : g_bad_w
    $error("mcspi_sync: width must be at least one");
  end

  // meta stage feeds only the stable stage
  always_comb begin
    st_nxt.meta   = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;
endmodule : mcspi_sync

/* File: mcspi_rategen.sv */
`timescale 1ns/1ps
module mcspi_rategen import mcspi_pkg::*; #(
  parameter int DIV_W = DEF_DIV_W
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // control
  input  wire logic             run,
  input  wire logic             src_cpu,
  input  wire logic             ext_tick,
  input  wire logic             restart,
  input  wire logic [DIV_W-1:0] div,
  // generated clock and its edges
  output logic                  gen_level,
  output logic                  gen_rise,
  output logic                  gen_fall
);
  localparam int LW = DIV_W + 1;

  typedef struct packed {
    logic [LW-1:0] cnt;
    logic          level;
    logic          rise;
    logic          fall;
  } mcspi_rg_st_t;

  mcspi_rg_st_t  st_r;
  mcspi_rg_st_t  st_nxt;
  logic [LW-1:0] dv;
  logic [LW-1:0] half;
  logic [LW-1:0] half_up;
  logic [LW-1:0] hi_len;
  logic [LW-1:0] lo_len;
  logic [LW-1:0] phase_len;
  logic          tick;
  logic          toggle;

  if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div
    $error("mcspi_rategen: divide width out of range");
  end

  // phase lengths in input periods; zero divide cannot halve a tick, so it runs as one
  always_comb begin
    dv      = {1'b0, div};
    half    = dv >> 1;
    half_up = LW'(dv + LW'(1)) >> 1;
    if (dv == '0) begin
      hi_len = LW'(1);
      lo_len = LW'(1);
    end else if (!dv[0]) begin
      hi_len = LW'(half + LW'(1));
      lo_len = half;
    end else begin
      hi_len = half_up;
      lo_len = half_up;
    end
    phase_len = st_r.level ? hi_len : lo_len;
    tick      = src_cpu | ext_tick;
    toggle    = run && !restart && tick && (LW'(st_r.cnt + LW'(1)) >= phase_len);
  end

  // one phase counter; high plus low makes the divide-plus-one period
  always_comb begin
    st_nxt      = st_r;
    st_nxt.rise = 1'b0;
    st_nxt.fall = 1'b0;
    if (!run || restart) begin
      st_nxt.cnt   = '0;
      st_nxt.level = 1'b0;
    end else if (toggle) begin
      st_nxt.cnt   = '0;
      st_nxt.level = ~st_r.level;
      st_nxt.rise  = ~st_r.level;
      st_nxt.fall  = st_r.level;
    end else if (tick) begin
      st_nxt.cnt = LW'(st_r.cnt + LW'(1));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign gen_level = st_r.level;
  assign gen_rise  = st_r.rise;
  assign gen_fall  = st_r.fall;

  // phase tick count, valid only while divide and source held since the phase began
  logic [LW-1:0]    h_ticks_r;
  logic             h_clean_r;
  logic [DIV_W-1:0] h_div_r;
  logic             h_src_r;
  logic             h_ok;
  // a divide or source change in the toggle cycle itself spoils that phase too
  assign h_ok = h_clean_r && (div == h_div_r) && (src_cpu == h_src_r);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      h_ticks_r <= '0;
      h_clean_r <= 1'b0;
      h_div_r   <= '0;
      h_src_r   <= 1'b0;
    end else begin
      h_div_r <= div;
      h_src_r <= src_cpu;
      if (!run || restart || toggle) begin
        h_ticks_r <= '0;
        h_clean_r <= 1'b1;
      end else begin
        if (tick) begin
          h_ticks_r <= LW'(h_ticks_r + LW'(1));
        end
        if (div != h_div_r || src_cpu != h_src_r) begin
          h_clean_r <= 1'b0;
        end
      end
    end
  end

  property p_high_len;
    @(posedge clk_sys) disable iff (sys_rst)
      st_r.fall && $past(h_ok) |-> $past(h_ticks_r) == LW'($past(hi_len) - LW'(1));
  endproperty
  a_high_len: assert property (p_high_len) else $error("high phase length wrong");

  property p_low_len;
    @(posedge clk_sys) disable iff (sys_rst)
      st_r.rise && $past(h_ok) && $past(run) |->
        $past(h_ticks_r) == LW'($past(lo_len) - LW'(1));
  endproperty
  a_low_len: assert property (p_low_len) else $error("low phase length wrong");

  property p_ext_only;
    @(posedge clk_sys) disable iff (sys_rst)
      run && !restart && !src_cpu && !ext_tick |=> $stable(st_r.level) && $stable(st_r.cnt);
  endproperty
  a_ext_only: assert property (p_ext_only) else $error("moved without rate pin edge");
endmodule : mcspi_rategen

/* File: mcspi_peer.sv */
`timescale 1ns/1ps
module mcspi_peer (
  // serial pins seen from the far device
  input  wire logic       sclk,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  // mode and data
  input  wire logic       dly,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic      [7:0] rx_byte
);
  logic [7:0] sr    = 8'h00;
  logic       first = 1'b0;
  // a released line shows the inverse of the last bit, so stale data cannot pass
  assign miso = (ss_n !== 1'b0) ? ~sr[7] : sr[7];
  // first bit is ready before the first rising edge of the transfer
  always @(negedge ss_n) begin
    sr = tx_byte;
    first = 1'b1;
  end
  // delay mode samples on rise; no-delay mode launches on every rise but the first
  always @(posedge sclk) begin
    if (!ss_n) begin
      if (dly) rx_byte = {rx_byte[6:0], mosi};
      else if (!first) sr = {sr[6:0], 1'b0};
      first = 1'b0;
    end
  end
  // the opposite edge does the other half of each mode
  always @(negedge sclk) begin
    if (!ss_n) begin
      if (dly) sr = {sr[6:0], 1'b0};
      else rx_byte = {rx_byte[6:0], mosi};
    end
  end
endmodule : mcspi_peer

/* File: serial_port_spi_clocking_test.sv */
`timescale 1ns/1ps
module serial_port_spi_clocking_test;
  import mcspi_pkg::*;
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  logic              reg_wr  = 1'b0;
  logic              reg_rd  = 1'b0;
  logic              rate_clk_i = 1'b0;
  logic              rk = 1'b0;
  logic              ck_tb = 1'b0;
  logic              ss_tb = 1'b1;
  logic              dly = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic              sdi, ck_o, ck_oe, fs_o, fs_oe, sdo, sdo_oe, ck_q, ss_q, oe_q;
  logic [7:0]        ptx = 8'h00;
  logic [7:0]        prx;
  int                n_errors = 0, comparisons = 0, cyc = 0;
  int                t_sf, t_r1, t_r2, t_f1, t_lf, t_sr, t_oe, nr, nf;
  // whoever enables its driver owns the wire
  wire ck_w = (ck_oe === 1'b1) ? ck_o : ck_tb;
  wire fs_w = (fs_oe === 1'b1) ? fs_o : ss_tb;
  always #12.5 clk_sys = ~clk_sys;

  mcspi_top uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rate_clk_i(rate_clk_i),
    .transmit_bit_clock_i(ck_w), .transmit_bit_clock_o(ck_o), .transmit_bit_clock_oe(ck_oe),
    .transmit_frame_sync_i(fs_w), .transmit_frame_sync_o(fs_o),
    .transmit_frame_sync_oe(fs_oe), .receive_frame_sync_i(fs_w),
    .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_out_oe(sdo_oe));
  mcspi_peer peer (.sclk(ck_w), .ss_n(fs_w), .mosi(sdo), .dly(dly), .tx_byte(ptx),
    .miso(sdi), .rx_byte(prx));

  // rate pin at a quarter of the system clock, pin edge timestamps, hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    rk <= ~rk;
    if (rk) rate_clk_i <= ~rate_clk_i;
    ck_q <= ck_w;
    ss_q <= fs_w;
    oe_q <= sdo_oe;
    if (ss_q && !fs_w) begin
      t_sf <= cyc;
      nr <= 0;
      nf <= 0;
    end else begin
      if (!ck_q && ck_w) begin
        nr <= nr + 1;
        if (nr == 0) t_r1 <= cyc;
        if (nr == 1) t_r2 <= cyc;
      end
      if (ck_q && !ck_w) begin
        nf <= nf + 1;
        if (nf == 0) t_f1 <= cyc;
        t_lf <= cyc;
      end
    end
    if (!ss_q && fs_w) t_sr <= cyc;
    if (oe_q && !sdo_oe) t_oe <= cyc;
    if (cyc > 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // reset values, unmapped place reads zero and ignores writes
  task automatic test_regs();
    logic [31:0] d;
    rd(ADDR_CTRL, d);
    chk(d, {21'h0, CFG_RST});
    rd(ADDR_DIV, d);
    chk(d, 32'h0);
    wr(5'h14, 32'hffffffff);
    rd(5'h14, d);
    chk(d, 32'h0);
  endtask : test_regs

  // one master word; widths in system cycles worked out from the divide value
  task automatic master(input logic d3, input logic cpu, input int div, input int s,
                        input logic [7:0] tx, input logic [7:0] px);
    int h, l, t, i;
    logic [31:0] d;
    h = (div % 2 == 0) ? (div / 2 + 1) * s : (div + 1) / 2 * s;
    l = (div % 2 == 0) ? div / 2 * s : h;
    t = (div + 1) * s;
    dly = d3;
    ptx = px;
    wr(ADDR_DIV, div);
    wr(ADDR_CTRL, 32'h1eb | (cpu ? 32'h200 : 32'h0) | (d3 ? 32'h4 : 32'h0));
    wr(ADDR_TX, {24'h0, tx});
    d = 32'h1;
    for (i = 0; i < 400 && d[0] !== 1'b0; i++) rd(ADDR_STAT, d);
    repeat (4) @(posedge clk_sys);
    chk(d[0], 1'b0);
    chk(d[1], 1'b1);
    chk(fs_o, 1'b1);
    chk({ck_oe, fs_oe}, 2'h3);
    chk(t_f1 - t_r1, h);
    chk(t_r2 - t_f1, l);
    chk(t_r2 - t_r1, t);
    chk(t_r1 - t_sf, d3 ? t : l);
    chk(t_sr - t_lf, d3 ? l : t);
    chk(t_oe - t_lf, d3 ? 0 : l);
    chk(prx, tx);
    rd(ADDR_RX, d);
    chk(d, px);
    rd(ADDR_STAT, d);
    chk(d[1], 1'b0);
  endtask : master

  // slave: clock edges while deselected are ignored, output follows the enable pin
  task automatic slave();
    int i;
    wr(ADDR_DIV, 32'h1);
    wr(ADDR_CTRL, 32'h269);
    wr(ADDR_TX, 32'ha5);
    repeat (8) begin
      @(posedge clk_sys);
      ck_tb <= ~ck_tb;
      chk(sdo_oe, 1'b0);
    end
    chk({ck_oe, fs_oe}, 2'h0);
    ss_tb <= 1'b0;
    for (i = 0; i < 6 && sdo_oe !== 1'b1; i++) @(posedge clk_sys);
    #1 chk(sdo_oe, 1'b1);
    chk(sdo, 1'b1);
    @(posedge clk_sys);
    ss_tb <= 1'b1;
    for (i = 0; i < 6 && sdo_oe !== 1'b0; i++) @(posedge clk_sys);
    #1 chk(sdo_oe, 1'b0);
    // inverted clock polarity parks the idle master clock high
    wr(ADDR_CTRL, 32'h3fb);
    repeat (3) @(posedge clk_sys);
    chk(ck_o, 1'b1);
  endtask : slave

  task automatic wrap_up();
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    test_regs();
    master(1'b0, 1'b1, 8, 1, 8'ha5, 8'h3c);
    master(1'b1, 1'b0, 3, 4, 8'h69, 8'hc3);
    slave();
    wrap_up();
  end
endmodule : serial_port_spi_clocking_test
